//--- inc/oscm_pkg.sv
// clock select and fail-safe monitor: shared constants and types
// assumes a 40 MHz system clock and APB register access
package oscm_pkg;
  localparam logic [11:0] CTRL_ADDR      = 12'h000;
  localparam logic [11:0] STAT_ADDR      = 12'h004;
  localparam logic [11:0] CFG_ADDR       = 12'h008;
  localparam int          GO_BIT         = 0;
  localparam int          KEEP_BIT       = 1;
  localparam int          FAIL_BIT       = 3;
  localparam int          LOCK_BIT       = 5;
  localparam logic [7:0]  LOW_KEY_A      = 8'h46;
  localparam logic [7:0]  LOW_KEY_B      = 8'h57;
  localparam logic [7:0]  HIGH_KEY_A     = 8'h78;
  localparam logic [7:0]  HIGH_KEY_B     = 8'h9a;
  localparam logic [2:0]  GRP_SECONDARY  = 3'h0;
  localparam logic [2:0]  GRP_FAST_RC    = 3'h1;
  localparam logic [2:0]  GRP_LOW_RC     = 3'h2;
  localparam logic [2:0]  GRP_PRIMARY    = 3'h3;
  localparam logic [2:0]  GRP_FAST_PLL   = 3'h7;
  localparam logic [4:0]  PRI_PLL4       = 5'h05;
  localparam logic [4:0]  PRI_PLL8       = 5'h06;
  localparam logic [4:0]  PRI_PLL16      = 5'h07;
  localparam int          START_UP_COUNT = 1024;
  localparam int          FAIL_WINDOW    = 4;
  localparam logic [1:0]  KEY_LOW_PEND   = 2'h1;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ONE  = 2'b01,
    KEY_OPEN = 2'b10
  } oscm_key_type;

  typedef struct packed {
    logic [2:0] group_select;
    logic [4:0] primary_choice;
    logic [1:0] switch_monitor;
    logic       watchdog_on;
  } oscm_cfg_type;

  typedef struct packed {
    logic [2:0] active_group;
    logic [4:0] pll_multiplier;
    logic       secondary_run;
    logic       low_rc_run;
    logic       clock_hold;
    logic [3:0] trim;
  } oscm_out_type;
endpackage : oscm_pkg

//--- logic/oscm_unlock.sv
// byte-lane unlock sequencer for one byte of the control register
// assumes one byte write per apb access phase
`timescale 1ns/1ps
module oscm_unlock (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] data_i,
  input  wire logic [7:0] key_a_i,
  input  wire logic [7:0] key_b_i,
  output logic            open_o
);
  import oscm_pkg::*;
  oscm_key_type state_reg;

  // any other write breaks the sequence; open lasts one write only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= KEY_IDLE;
    end else if (wr_i) begin
      case (state_reg)
        KEY_IDLE: state_reg <= (data_i == key_a_i) ? KEY_ONE : KEY_IDLE;
        KEY_ONE:  state_reg <= (data_i == key_b_i) ? KEY_OPEN : KEY_IDLE;
        KEY_OPEN: state_reg <= (data_i == key_a_i) ? KEY_ONE : KEY_IDLE;
        default:  state_reg <= KEY_IDLE;
      endcase
    end
  end
  assign open_o = (state_reg == KEY_OPEN);
endmodule : oscm_unlock

//--- logic/oscm_top.sv
// clock selection, start-up timing and fail-safe supervision
// assumes oscillator and pll status inputs synchronous to clk_i
`timescale 1ns/1ps
module oscm_top (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire oscm_pkg::oscm_cfg_type cfg_i,
  input  wire logic                  osc_tick_i,
  input  wire logic                  low_rc_tick_i,
  input  wire logic                  pll_locked_i,
  input  wire logic                  sleep_i,
  input  wire logic                  power_up_done_i,
  input  wire logic                  brown_out_i,
  output oscm_pkg::oscm_out_type     clk_ctl_o,
  output logic                       fail_trap_o,
  output logic                       watchdog_clk_run_o
);
  import oscm_pkg::*;

  logic [2:0]  cur_reg;
  logic [2:0]  new_reg;
  logic        keep_reg;
  logic        fail_reg;
  logic        go_reg;
  logic [3:0]  trim_reg;
  logic [9:0]  start_cnt_reg;
  logic        start_done_reg;
  logic [7:0]  fail_cnt_reg;
  logic        was_bor_reg;
  logic        init_reg;
  logic        wr_access;
  logic        wr_low;
  logic        wr_high;
  logic        low_open;
  logic        high_open;
  logic        switch_on;
  logic        monitor_on;
  logic        crystal_src;
  logic        pll_src;
  logic        source_ready;
  logic        clock_fail;
  logic [2:0]  eff_group;
  logic [15:0] ctrl_view;

  assign wr_access  = psel_i & penable_i & pwrite_i & (paddr_i == CTRL_ADDR);
  assign wr_low     = wr_access & pstrb_i[0];
  assign wr_high    = wr_access & pstrb_i[1];
  assign switch_on  = ~cfg_i.switch_monitor[1];
  assign monitor_on = ~cfg_i.switch_monitor[1] & ~cfg_i.switch_monitor[0];

  oscm_unlock u_low (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (wr_low),
    .data_i    (pwdata_i[7:0]),
    .key_a_i   (LOW_KEY_A),
    .key_b_i   (LOW_KEY_B),
    .open_o    (low_open)
  );

  oscm_unlock u_high (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (wr_high),
    .data_i    (pwdata_i[15:8]),
    .key_a_i   (HIGH_KEY_A),
    .key_b_i   (HIGH_KEY_B),
    .open_o    (high_open)
  );

  // active group: config when switching is off
  assign eff_group = switch_on ? cur_reg : cfg_i.group_select;
  assign crystal_src = (eff_group == GRP_SECONDARY) |
                       ((eff_group == GRP_PRIMARY) &
                        (cfg_i.primary_choice > PRI_PLL16));
  assign pll_src = ((eff_group == GRP_FAST_PLL) &
                    (cfg_i.primary_choice >= PRI_PLL4) &
                    (cfg_i.primary_choice <= PRI_PLL16));
  assign source_ready = start_done_reg & (~pll_src | pll_locked_i);

  // start-up counter in oscillator periods
  always_ff @(posedge clk_i) begin
    if (sys_rst_i | sleep_i | (go_reg & ~source_ready)) begin
      start_cnt_reg  <= '0;
      start_done_reg <= 1'b0;
    end else if (~crystal_src) begin
      start_done_reg <= 1'b1;
    end else if (osc_tick_i & ~start_done_reg) begin
      start_cnt_reg  <= start_cnt_reg + 10'h001;
      start_done_reg <= (start_cnt_reg == 10'(START_UP_COUNT - 1));
    end
  end

  // clock-edge watchdog: count rc ticks since last oscillator tick
  always_ff @(posedge clk_i) begin
    if (sys_rst_i | osc_tick_i | ~monitor_on | sleep_i) begin
      fail_cnt_reg <= '0;
    end else if (low_rc_tick_i & (fail_cnt_reg != 8'(FAIL_WINDOW))) begin
      fail_cnt_reg <= fail_cnt_reg + 8'h01;
    end
  end
  assign clock_fail = monitor_on & (eff_group != GRP_FAST_RC) &
    ((fail_cnt_reg == 8'(FAIL_WINDOW)) |
     (power_up_done_i & ~start_done_reg & crystal_src));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      was_bor_reg <= 1'b0;
      init_reg    <= 1'b1;
    end else begin
      init_reg <= 1'b0;
      if (init_reg) was_bor_reg <= brown_out_i;
    end
  end

  // control register fields
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cur_reg  <= 3'h0;
      new_reg  <= 3'h0;
      keep_reg <= 1'b0;
      fail_reg <= 1'b0;
      go_reg   <= 1'b0;
      trim_reg <= 4'h0;
    end else if (init_reg) begin
      cur_reg <= cfg_i.group_select;
      new_reg <= cfg_i.group_select;
    end else begin
      if (clock_fail) begin
        cur_reg  <= GRP_FAST_RC;
        fail_reg <= 1'b1;
        go_reg   <= 1'b0;
      end else if (go_reg & source_ready) begin
        cur_reg <= new_reg;
        go_reg  <= 1'b0;
      end
      if (low_open & wr_low & ~clock_fail) begin
        go_reg   <= pwdata_i[GO_BIT] & switch_on;
        keep_reg <= pwdata_i[KEEP_BIT];
      end
      if (high_open & wr_high) begin
        new_reg  <= pwdata_i[10:8];
        trim_reg <= {pwdata_i[15:14], pwdata_i[11:10]};
      end
    end
  end

  // bits 14 and 10 are shared: group fields win, full trim in 19:16
  assign ctrl_view = {trim_reg[3], cur_reg, trim_reg[1], new_reg,
                      2'b00, pll_locked_i, 1'b0, fail_reg,
                      1'b0, keep_reg, go_reg};

  // apb slave: zero-wait, errors on unmapped addresses
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prdata_o  <= '0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & (paddr_i != CTRL_ADDR) &
                   (paddr_i != STAT_ADDR) & (paddr_i != CFG_ADDR);
      case (paddr_i)
        CTRL_ADDR: prdata_o <= {12'h000, trim_reg,
                                ctrl_view};
        STAT_ADDR: prdata_o <= {29'h0, start_done_reg, switch_on,
                                monitor_on};
        CFG_ADDR:  prdata_o <= {21'h0, cfg_i};
        default:   prdata_o <= '0;
      endcase
    end
  end

  // clock steering outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clk_ctl_o          <= '0;
      fail_trap_o        <= 1'b0;
      watchdog_clk_run_o <= 1'b1;
    end else begin
      fail_trap_o <= clock_fail & ~fail_reg;
      clk_ctl_o.active_group <= eff_group;
      clk_ctl_o.trim         <= trim_reg;
      case (cfg_i.primary_choice)
        PRI_PLL4:  clk_ctl_o.pll_multiplier <= pll_src ? 5'h04 : 5'h01;
        PRI_PLL8:  clk_ctl_o.pll_multiplier <= pll_src ? 5'h08 : 5'h01;
        PRI_PLL16: clk_ctl_o.pll_multiplier <= pll_src ? 5'h10 : 5'h01;
        default:   clk_ctl_o.pll_multiplier <= 5'h01;
      endcase
      clk_ctl_o.secondary_run <= keep_reg |
                                 (eff_group == GRP_SECONDARY);
      clk_ctl_o.low_rc_run <= ~power_up_done_i |
        (monitor_on & ~sleep_i) | cfg_i.watchdog_on |
        (eff_group == GRP_LOW_RC);
      clk_ctl_o.clock_hold <= ~start_done_reg |
        (was_bor_reg & pll_src & ~pll_locked_i);
      watchdog_clk_run_o <= cfg_i.watchdog_on | ~power_up_done_i |
                            monitor_on;
    end
  end
endmodule : oscm_top

//--- tb/oscm_top_asserts.sv
// port checker for the clock select and fail-safe monitor
// assumes it is bound to oscm_top, single clock domain
`timescale 1ns/1ps
module oscm_top_asserts
  import oscm_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         sys_rst_i,
  input wire logic         psel_i,
  input wire logic         penable_i,
  input wire logic [11:0]  paddr_i,
  input wire logic         pready_o,
  input wire logic         pslverr_o,
  input wire oscm_cfg_type cfg_i,
  input wire logic         sleep_i,
  input wire oscm_out_type clk_ctl_o,
  input wire logic         fail_trap_o,
  input wire logic         watchdog_clk_run_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic mapped;
  assign mapped = paddr_i inside {CTRL_ADDR, STAT_ADDR, CFG_ADDR};
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence pll16_s;
    clk_ctl_o.active_group == GRP_FAST_PLL ##1
      clk_ctl_o.active_group == GRP_FAST_PLL &&
      cfg_i.primary_choice == PRI_PLL16 && $stable(cfg_i.primary_choice);
  endsequence
  ready_next_a: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held two cycles");
  err_unmapped_a: assert property (setup_s ##0 !mapped |=> pslverr_o)
    else $error("no error on unmapped address");
  err_mapped_a: assert property (setup_s ##0 mapped |=> !pslverr_o)
    else $error("error on mapped address");
  trap_fast_a: assert property (
    $rose(fail_trap_o) |-> ##[0:2] clk_ctl_o.active_group == GRP_FAST_RC)
    else $error("trap without fast rc");
  trap_off_a: assert property (
    cfg_i.switch_monitor[1] && $past(cfg_i.switch_monitor[1])
      |-> !fail_trap_o)
    else $error("trap with monitor off");
  wdog_rc_a: assert property (
    cfg_i.watchdog_on && $past(cfg_i.watchdog_on) && !sleep_i
      |=> clk_ctl_o.low_rc_run)
    else $error("low rc stopped with watchdog on");
  wdog_fail_a: assert property (
    fail_trap_o && cfg_i.watchdog_on |-> watchdog_clk_run_o)
    else $error("watchdog clock lost on failure");
  pll_mult_a: assert property (
    pll16_s |-> clk_ctl_o.pll_multiplier == 5'h10)
    else $error("wrong pll multiplier");
endmodule : oscm_top_asserts
bind oscm_top oscm_top_asserts chk_u (.*);

//--- tb/oscm_osc_model.sv
// oscillator, low-power rc and pll stand-in
// assumes ticks are counted in system clock cycles
`timescale 1ns/1ps
module oscm_osc_model #(
  parameter int OSC_DIV = 4,
  parameter int RC_DIV  = 16
) (
  input  wire logic clk_i,
  input  wire logic run_i,
  output logic      osc_tick_o = 1'b0,
  output logic      rc_tick_o  = 1'b0,
  output logic      locked_o   = 1'b0
);
  int osc_cnt = 0;
  int rc_cnt  = 0;
  always @(posedge clk_i) begin
    osc_cnt <= (osc_cnt + 1) % OSC_DIV;
    rc_cnt <= (rc_cnt + 1) % RC_DIV;
    osc_tick_o <= run_i && osc_cnt == 0;
    rc_tick_o <= rc_cnt == 0;
    locked_o <= run_i;
  end
endmodule : oscm_osc_model

//--- tb/test_oscm_top.sv
// self-checking bench for the clock select and fail-safe monitor
// assumes oscm_osc_model feeds the oscillator tick inputs
`timescale 1ns/1ps
module test_oscm_top;
  import oscm_pkg::*;
  logic         clk_i           = 1'b0;
  logic         sys_rst_i       = 1'b1;
  logic         psel_i          = 1'b0;
  logic         penable_i       = 1'b0;
  logic         pwrite_i        = 1'b0;
  logic [11:0]  paddr_i         = 12'h000;
  logic [31:0]  pwdata_i        = 32'h0;
  logic [3:0]   pstrb_i         = 4'h0;
  oscm_cfg_type cfg_i = '{GRP_PRIMARY, 5'h08, 2'b00, 1'b1};
  logic         sleep_i         = 1'b0;
  logic         power_up_done_i = 1'b0;
  logic         brown_out_i     = 1'b0;
  logic         osc_run         = 1'b1;
  logic [31:0]  prdata_o, rd;
  logic         pready_o, pslverr_o, err, seen;
  logic         osc_tick_i, low_rc_tick_i, pll_locked_i;
  logic         fail_trap_o, watchdog_clk_run_o;
  oscm_out_type clk_ctl_o;
  int           miscompares = 0;
  int           checks_done = 0;
  initial forever #12.5 clk_i = ~clk_i;
  oscm_top dut (.*);
  oscm_osc_model osc (.clk_i(clk_i), .run_i(osc_run),
    .osc_tick_o(osc_tick_i), .rc_tick_o(low_rc_tick_i),
    .locked_o(pll_locked_i));
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic ctl_byte(input int ln, input logic [7:0] ka,
                          input logic [7:0] kb, input logic [7:0] v);
    apb(1'b1, CTRL_ADDR, {4{ka}}, 4'h1 << ln);
    apb(1'b1, CTRL_ADDR, {4{kb}}, 4'h1 << ln);
    apb(1'b1, CTRL_ADDR, {4{v}}, 4'h1 << ln);
  endtask : ctl_byte
  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : do_reset
  task automatic t_start();
    apb(1'b0, CTRL_ADDR, 32'h0, 4'h0);
    chk("cur group", GRP_PRIMARY, rd[14:12]);
    apb(1'b0, 12'h00c, 32'h0, 4'h0);
    chk("unmapped err", 1, err);
    apb(1'b0, STAT_ADDR, 32'h0, 4'h0);
    chk("start pending", 0, rd[2]);
    chk("clock held", 1, clk_ctl_o.clock_hold);
    repeat (4300) @(posedge clk_i);
    power_up_done_i <= 1'b1;
    apb(1'b0, STAT_ADDR, 32'h0, 4'h0);
    chk("start done", 1, rd[2]);
  endtask : t_start
  task automatic t_fail();
    int n;
    osc_run <= 1'b0;
    for (n = 0; n < 300 && fail_trap_o !== 1'b1; n++) @(posedge clk_i);
    chk("trap", 1, fail_trap_o);
    chk("wdog run", 1, watchdog_clk_run_o);
    apb(1'b0, CTRL_ADDR, 32'h0, 4'h0);
    chk("fail group", GRP_FAST_RC, rd[14:12]);
    chk("fail flag", 1, rd[FAIL_BIT]);
    chk("go cleared", 0, rd[GO_BIT]);
    chk("lock bit", 0, rd[LOCK_BIT]);
    osc_run <= 1'b1;
  endtask : t_fail
  task automatic t_switch();
    int n;
    apb(1'b1, CTRL_ADDR, {4{8'h02}}, 4'h2);
    apb(1'b0, CTRL_ADDR, 32'h0, 4'h0);
    chk("locked new", GRP_PRIMARY, rd[10:8]);
    ctl_byte(1, HIGH_KEY_A, HIGH_KEY_B, {5'h00, GRP_LOW_RC});
    apb(1'b0, CTRL_ADDR, 32'h0, 4'h0);
    chk("new group", GRP_LOW_RC, rd[10:8]);
    chk("trim", 0, rd[19:16]);
    apb(1'b1, CTRL_ADDR, 32'h1, 4'h1);
    apb(1'b0, CTRL_ADDR, 32'h0, 4'h0);
    chk("locked go", GRP_FAST_RC, rd[14:12]);
    ctl_byte(0, LOW_KEY_A, LOW_KEY_B, 8'h03);
    for (n = 0; n < 40; n++) begin
      apb(1'b0, CTRL_ADDR, 32'h0, 4'h0);
      if (rd[GO_BIT] === 1'b0) break;
    end
    chk("go done", 0, rd[GO_BIT]);
    chk("switched", GRP_LOW_RC, rd[14:12]);
    chk("keep on", 1, clk_ctl_o.secondary_run);
  endtask : t_switch
  task automatic t_disabled();
    cfg_i <= '{GRP_FAST_PLL, PRI_PLL16, 2'b10, 1'b1};
    osc_run <= 1'b0;
    do_reset();
    seen = 1'b0;
    repeat (300) begin
      @(posedge clk_i);
      if (fail_trap_o === 1'b1) seen = 1'b1;
    end
    chk("no trap", 0, seen);
    chk("cfg group", GRP_FAST_PLL, clk_ctl_o.active_group);
    chk("pll x16", 16, clk_ctl_o.pll_multiplier);
    chk("no hold", 0, clk_ctl_o.clock_hold);
    chk("low rc run", 1, clk_ctl_o.low_rc_run);
  endtask : t_disabled
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
  initial begin
    do_reset();
    t_start();
    t_fail();
    t_switch();
    t_disabled();
    summarize();
  end
endmodule : test_oscm_top
